//--- shared/scrg_map.vh
// register offsets, field positions and constants of the serial clock rate generator
`ifndef SCRG_MAP_VH
`define SCRG_MAP_VH
`define SCRG_OFF_CLOCK_MODE 8'h00
`define SCRG_OFF_HW_CONFIG 8'h04
`define SCRG_OFF_TC_ZERO 8'h08
`define SCRG_OFF_TC_ONE 8'h0C
`define SCRG_OFF_STATUS 8'h10
`define SCRG_OFF_COMMAND 8'h14
`define SCRG_OFF_IRQ_CTRL 8'h18
`define SCRG_CM_PSB_SRC 15:14
`define SCRG_CM_PSA_SRC 13:12
`define SCRG_CM_RDB_SRC 11:10
`define SCRG_CM_RDA_SRC 9:8
`define SCRG_CM_TX_SRC 5:3
`define SCRG_CM_RX_SRC 2:0
`define SCRG_HC_PSA_DIV 15:14
`define SCRG_HC_PSB_DSEL 13
`define SCRG_HC_PLL_DIV 11:10
`define SCRG_HC_RDB_ONE_SHOT 5
`define SCRG_HC_RDB_RUN 4
`define SCRG_HC_RDA_ONE_SHOT 1
`define SCRG_HC_RDA_RUN 0
`define SCRG_ST_ZERO_A 1
`define SCRG_ST_ZERO_B 0
`define SCRG_CMD_FIELD 15:11
`define SCRG_CMD_SKIP 5
`define SCRG_CMD_LOAD_A 5'h08
`define SCRG_CMD_LOAD_B 5'h09
`define SCRG_CMD_LOAD_AB 5'h0A
`define SCRG_IC_SEL_A 0
`define SCRG_IC_SEL_B 1
`define SCRG_IC_ARM_A 2
`define SCRG_IC_ARM_B 3
`define SCRG_IC_MISCELLANEOUS_IRQ_ENABLE 4
`define SCRG_IC_MASTER_IE 5
`define SCRG_IC_ASYNC_MUL 7:6
`define SCRG_RESP_OKAY 2'h0
`define SCRG_RESP_SLVERR 2'h2
`endif

//--- core/scrg_rate_gen.v
// serial clock prescalers, rate dividers, clock selection and register slave
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "scrg_map.vh"
module scrg_rate_gen #(
    parameter CW = 16
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire receive_clock_pin,
    input wire transmit_clock_pin,
    input wire port_pin_a,
    input wire port_pin_b,
    input wire pll_receive_clock,
    input wire pll_transmit_clock,
    input wire [2:0] receive_pin_drive_sel,
    input wire [2:0] transmit_pin_drive_sel,
    input wire [1:0] pll_reference_sel,
    output reg receive_bit_clock,
    output reg transmit_bit_clock,
    output reg pll_reference,
    output reg receive_clock_pin_out,
    output reg receive_clock_pin_oe,
    output reg transmit_clock_pin_out,
    output reg transmit_clock_pin_oe,
    output reg rx_sample_en,
    output reg tx_shift_en,
    output reg rx_bit_tick,
    output reg tx_bit_tick,
    output reg zero_irq
);
    // =====================================================================
    // register bus slave
    // =====================================================================
    reg [15:0] clock_mode_control_q;
    reg [15:0] hardware_configuration_q;
    reg [15:0] time_constant_zero_q;
    reg [15:0] time_constant_one_q;
    reg [15:0] capture_a_q;
    reg [15:0] capture_b_q;
    reg [7:0] irq_ctrl_q;
    reg prescaler_skip_q;
    reg [1:0] zero_flag_q;
    reg [7:0] waddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg aw_have_q;
    reg w_have_q;
    reg [15:0] count_a_q;
    reg [15:0] count_b_q;
    wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    wire wr_lo = wstrb_q[0];
    wire wr_hi = wstrb_q[1];
    wire [15:0] wd = wdata_q[15:0];
    wire [4:0] cmd = wd[`SCRG_CMD_FIELD];
    wire cmd_wr = do_write && waddr_q == `SCRG_OFF_COMMAND && wr_hi;
    wire load_a = cmd_wr && (cmd == `SCRG_CMD_LOAD_A || cmd == `SCRG_CMD_LOAD_AB);
    wire load_b = cmd_wr && (cmd == `SCRG_CMD_LOAD_B || cmd == `SCRG_CMD_LOAD_AB);
    wire ic_wr = do_write && waddr_q == `SCRG_OFF_IRQ_CTRL && wr_lo;

    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready = !w_have_q;
    assign s_axi_arready = !s_axi_rvalid;

    function [15:0] merge;
        input [15:0] old;
        input [15:0] nw;
        input lo;
        input hi;
        begin
            merge = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = a == `SCRG_OFF_CLOCK_MODE || a == `SCRG_OFF_HW_CONFIG ||
                a == `SCRG_OFF_TC_ZERO || a == `SCRG_OFF_TC_ONE ||
                a == `SCRG_OFF_STATUS || a == `SCRG_OFF_COMMAND ||
                a == `SCRG_OFF_IRQ_CTRL;
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SCRG_RESP_OKAY;
            clock_mode_control_q <= 16'h0000;
            hardware_configuration_q <= 16'h0000;
            time_constant_zero_q <= 16'h0000;
            time_constant_one_q <= 16'h0000;
            irq_ctrl_q <= 8'h00;
            prescaler_skip_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                waddr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(waddr_q) ? `SCRG_RESP_OKAY : `SCRG_RESP_SLVERR;
                case (waddr_q)
                    `SCRG_OFF_CLOCK_MODE: begin
                        clock_mode_control_q <= merge(clock_mode_control_q, wd, wr_lo, wr_hi);
                    end
                    `SCRG_OFF_HW_CONFIG: begin
                        hardware_configuration_q <=
                            merge(hardware_configuration_q, wd, wr_lo, wr_hi);
                    end
                    `SCRG_OFF_TC_ZERO: begin
                        time_constant_zero_q <= merge(time_constant_zero_q, wd, wr_lo, wr_hi);
                    end
                    `SCRG_OFF_TC_ONE: begin
                        time_constant_one_q <= merge(time_constant_one_q, wd, wr_lo, wr_hi);
                    end
                    `SCRG_OFF_COMMAND: begin
                        if (wr_lo) begin
                            prescaler_skip_q <= wd[`SCRG_CMD_SKIP];
                        end
                    end
                    `SCRG_OFF_IRQ_CTRL: begin
                        if (wr_lo) begin
                            irq_ctrl_q <= wd[7:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // read-select capture: writing a one latches the live count
    always @(posedge aclk) begin
        if (!aresetn) begin
            capture_a_q <= 16'h0000;
            capture_b_q <= 16'h0000;
        end else begin
            if (ic_wr && wd[`SCRG_IC_SEL_A]) begin
                capture_a_q <= count_a_q;
            end
            if (ic_wr && wd[`SCRG_IC_SEL_B]) begin
                capture_b_q <= count_b_q;
            end
        end
    end

    reg [15:0] rd_val;
    always @* begin
        case ({s_axi_araddr[7:2], 2'b00})
            `SCRG_OFF_CLOCK_MODE: rd_val = clock_mode_control_q;
            `SCRG_OFF_HW_CONFIG: rd_val = hardware_configuration_q;
            `SCRG_OFF_TC_ZERO: rd_val = irq_ctrl_q[`SCRG_IC_SEL_A] ? capture_a_q :
                time_constant_zero_q;
            `SCRG_OFF_TC_ONE: rd_val = irq_ctrl_q[`SCRG_IC_SEL_B] ? capture_b_q :
                time_constant_one_q;
            `SCRG_OFF_STATUS: rd_val = {14'h0000, zero_flag_q};
            `SCRG_OFF_COMMAND: rd_val = {10'h000, prescaler_skip_q, 5'h00};
            `SCRG_OFF_IRQ_CTRL: rd_val = {8'h00, irq_ctrl_q};
            default: rd_val = 16'h0000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SCRG_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_val};
            s_axi_rresp <= mapped({s_axi_araddr[7:2], 2'b00}) ? `SCRG_RESP_OKAY :
                `SCRG_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // =====================================================================
    // prescalers: edge detect of sampled clock inputs, 5-bit dividers
    // =====================================================================
    reg [3:0] pin_prev_q;
    wire [3:0] pin_now = {port_pin_b, port_pin_a, transmit_clock_pin, receive_clock_pin};
    wire [3:0] pin_rise = pin_now & ~pin_prev_q;
    wire [1:0] prescaler_a_source = clock_mode_control_q[`SCRG_CM_PSA_SRC];
    wire [1:0] prescaler_b_source = clock_mode_control_q[`SCRG_CM_PSB_SRC];
    wire [1:0] prescaler_a_divide = hardware_configuration_q[`SCRG_HC_PSA_DIV];
    wire prescaler_b_divide_select = hardware_configuration_q[`SCRG_HC_PSB_DSEL];
    wire [1:0] pll_divide = hardware_configuration_q[`SCRG_HC_PLL_DIV];
    wire [1:0] psb_div = prescaler_b_divide_select ? pll_divide : prescaler_a_divide;
    wire [1:0] ps_src [0:1];
    wire [1:0] ps_div [0:1];
    wire [1:0] ps_port_lvl = {port_pin_b, port_pin_a};
    wire [1:0] ps_port_rise = pin_rise[3:2];
    wire [1:0] ps_out;
    wire [1:0] ps_rise;
    assign ps_src[0] = prescaler_a_source;
    assign ps_src[1] = prescaler_b_source;
    assign ps_div[0] = prescaler_a_divide;
    assign ps_div[1] = psb_div;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_pre
            reg [4:0] cnt_q;
            reg tick;
            reg [4:0] top;
            always @* begin
                case (ps_src[g])
                    2'b01: tick = ps_port_rise[g];
                    2'b10: tick = pin_rise[0];
                    2'b11: tick = pin_rise[1];
                    default: tick = 1'b0;
                endcase
                case (ps_div[g])
                    2'b00: top = 5'h1F;
                    2'b01: top = 5'h0F;
                    2'b10: top = 5'h07;
                    default: top = 5'h03;
                endcase
            end
            always @(posedge aclk) begin
                if (!aresetn) begin
                    cnt_q <= 5'h00;
                end else if (ps_src[g] == 2'b00) begin
                    cnt_q <= 5'h00;
                end else if (tick) begin
                    cnt_q <= (cnt_q >= top) ? 5'h00 : cnt_q + 5'h01;
                end
            end
            wire half = (ps_div[g] == 2'b00) ? cnt_q[4] : (ps_div[g] == 2'b01) ? cnt_q[3] :
                (ps_div[g] == 2'b10) ? cnt_q[2] : cnt_q[1];
            assign ps_out[g] = prescaler_skip_q ? ps_port_lvl[g] : half;
            assign ps_rise[g] = prescaler_skip_q ? ps_port_rise[g] :
                (tick && cnt_q == top);
        end
    endgenerate

    // =====================================================================
    // rate dividers: 16-bit reloadable down counters, divide by N+1
    // =====================================================================
    wire [1:0] rate_divider_a_source = clock_mode_control_q[`SCRG_CM_RDA_SRC];
    wire [1:0] rate_divider_b_source = clock_mode_control_q[`SCRG_CM_RDB_SRC];
    wire [1:0] rd_src [0:1];
    wire [1:0] rd_run;
    wire [1:0] rd_one_shot;
    wire [1:0] rd_load;
    wire [15:0] rd_tc [0:1];
    wire [1:0] rd_zero;
    wire [1:0] rd_out;
    assign rd_src[0] = rate_divider_a_source;
    assign rd_src[1] = rate_divider_b_source;
    assign rd_run = {hardware_configuration_q[`SCRG_HC_RDB_RUN],
        hardware_configuration_q[`SCRG_HC_RDA_RUN]};
    assign rd_one_shot = {hardware_configuration_q[`SCRG_HC_RDB_ONE_SHOT],
        hardware_configuration_q[`SCRG_HC_RDA_ONE_SHOT]};
    assign rd_load = {load_b, load_a};
    assign rd_tc[0] = time_constant_zero_q;
    assign rd_tc[1] = time_constant_one_q;

    generate
        for (g = 0; g < 2; g = g + 1) begin : g_rate
            reg [CW-1:0] cnt_q;
            reg stopped_q;
            reg out_q;
            reg in_tick;
            always @* begin
                case (rd_src[g])
                    2'b00: in_tick = ps_rise[0];
                    2'b01: in_tick = ps_rise[1];
                    2'b10: in_tick = pin_rise[0];
                    default: in_tick = pin_rise[1];
                endcase
            end
            wire step = in_tick && rd_run[g] && !stopped_q;
            wire hit = step && cnt_q == {CW{1'b0}};
            always @(posedge aclk) begin
                if (!aresetn) begin
                    cnt_q <= {CW{1'b0}};
                    stopped_q <= 1'b0;
                    out_q <= 1'b0;
                end else if (rd_load[g]) begin
                    cnt_q <= rd_tc[g][CW-1:0];
                    stopped_q <= 1'b0;
                end else if (hit) begin
                    // periodic: one input period high per N+1 input periods; one-shot: stays high once stopped
                    out_q <= 1'b1;
                    if (rd_one_shot[g]) begin
                        stopped_q <= 1'b1;
                    end else begin
                        cnt_q <= rd_tc[g][CW-1:0];
                    end
                end else if (step) begin
                    out_q <= 1'b0;
                    cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
                end
            end
            // zero constant with the run bit set passes the input straight through
            assign rd_out[g] = (rd_tc[g] == 16'h0000 && rd_run[g]) ?
                (rd_src[g][1] ? pin_now[rd_src[g][0]] : ps_out[rd_src[g][0]]) : out_q;
            assign rd_zero[g] = hit;
        end
    endgenerate

    always @* begin
        count_a_q = g_rate[0].cnt_q;
        count_b_q = g_rate[1].cnt_q;
    end

    // sticky zero flags: set wins over write-one clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            zero_flag_q <= 2'b00;
        end else begin
            zero_flag_q <= (zero_flag_q & ~((do_write && waddr_q == `SCRG_OFF_STATUS &&
                wr_lo) ? wd[1:0] : 2'b00)) | {rd_zero[0], rd_zero[1]};
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            zero_irq <= 1'b0;
        end else begin
            zero_irq <= irq_ctrl_q[`SCRG_IC_MASTER_IE] && irq_ctrl_q[`SCRG_IC_MISCELLANEOUS_IRQ_ENABLE] &&
                ((zero_flag_q[`SCRG_ST_ZERO_A] && irq_ctrl_q[`SCRG_IC_ARM_A]) ||
                (zero_flag_q[`SCRG_ST_ZERO_B] && irq_ctrl_q[`SCRG_IC_ARM_B]));
        end
    end

    // =====================================================================
    // clock selection and bit timing enables
    // =====================================================================
    function sel8;
        input [2:0] s;
        input rp;
        input tp;
        input pl;
        input ra;
        input rb;
        input pa;
        input pb;
        begin
            case (s)
                3'h0: sel8 = 1'b0;
                3'h1: sel8 = rp;
                3'h2: sel8 = tp;
                3'h3: sel8 = pl;
                3'h4: sel8 = ra;
                3'h5: sel8 = rb;
                3'h6: sel8 = pa;
                default: sel8 = pb;
            endcase
        end
    endfunction

    reg rx_prev_q;
    reg tx_prev_q;
    reg [5:0] rx_div_q;
    reg [5:0] tx_div_q;
    wire [1:0] async_mul = irq_ctrl_q[`SCRG_IC_ASYNC_MUL];
    wire [5:0] mul_top = (async_mul == 2'b00) ? 6'h0F : (async_mul == 2'b01) ? 6'h1F :
        (async_mul == 2'b10) ? 6'h3F : 6'h00;
    wire rx_sel = sel8(clock_mode_control_q[`SCRG_CM_RX_SRC], receive_clock_pin,
        transmit_clock_pin, pll_receive_clock, rd_out[0], rd_out[1], ps_out[0], ps_out[1]);
    wire tx_sel = sel8(clock_mode_control_q[`SCRG_CM_TX_SRC], receive_clock_pin,
        transmit_clock_pin, pll_transmit_clock, rd_out[0], rd_out[1], ps_out[0], ps_out[1]);

    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_prev_q <= 4'h0;
            rx_prev_q <= 1'b0;
            tx_prev_q <= 1'b0;
            rx_div_q <= 6'h00;
            tx_div_q <= 6'h00;
            receive_bit_clock <= 1'b0;
            transmit_bit_clock <= 1'b0;
            pll_reference <= 1'b0;
            receive_clock_pin_out <= 1'b0;
            receive_clock_pin_oe <= 1'b0;
            transmit_clock_pin_out <= 1'b0;
            transmit_clock_pin_oe <= 1'b0;
            rx_sample_en <= 1'b0;
            tx_shift_en <= 1'b0;
            rx_bit_tick <= 1'b0;
            tx_bit_tick <= 1'b0;
        end else begin
            pin_prev_q <= pin_now;
            rx_prev_q <= rx_sel;
            tx_prev_q <= tx_sel;
            receive_bit_clock <= rx_sel;
            transmit_bit_clock <= tx_sel;
            pll_reference <= sel8({1'b0, pll_reference_sel} + 3'h4, 1'b0, 1'b0, 1'b0,
                rd_out[0], rd_out[1], receive_clock_pin, transmit_clock_pin);
            receive_clock_pin_oe <= receive_pin_drive_sel != 3'h0;
            receive_clock_pin_out <= sel8(receive_pin_drive_sel, 1'b0, 1'b0,
                pll_receive_clock, rd_out[0], rd_out[1], ps_out[0], ps_out[1]);
            transmit_clock_pin_oe <= transmit_pin_drive_sel != 3'h0;
            transmit_clock_pin_out <= sel8(transmit_pin_drive_sel, 1'b0, 1'b0,
                pll_transmit_clock, rd_out[0], rd_out[1], ps_out[0], ps_out[1]);
            rx_sample_en <= rx_sel && !rx_prev_q;
            tx_shift_en <= !tx_sel && tx_prev_q;
            rx_bit_tick <= rx_sel != rx_prev_q;
            tx_bit_tick <= tx_sel != tx_prev_q;
            if (rx_sel && !rx_prev_q) begin
                rx_div_q <= (rx_div_q >= mul_top) ? 6'h00 : rx_div_q + 6'h01;
            end
            if (!tx_sel && tx_prev_q) begin
                tx_div_q <= (tx_div_q >= mul_top) ? 6'h00 : tx_div_q + 6'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- test/scrg_rate_gen_monitor.sv
// assertions on the register bus and bit clock strobes of the rate generator
`timescale 1ns/1ns
`default_nettype none
module scrg_rate_gen_monitor (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [2:0] receive_pin_drive_sel,
    input wire receive_bit_clock,
    input wire transmit_bit_clock,
    input wire receive_clock_pin_oe,
    input wire rx_sample_en,
    input wire rx_bit_tick,
    input wire tx_shift_en,
    input wire zero_irq
);
    // ====
    // properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_r_wait; s_axi_rvalid && !s_axi_rready; endsequence
    property p_rd_answer; s_ar_take |=> s_axi_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
    property p_rd_unmapped;
        s_ar_take ##0 s_axi_araddr >= 8'h1C |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read answer");
    property p_r_hold; s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_reset_quiet;
        $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !zero_irq && !receive_bit_clock;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
    property p_rx_sample; $rose(receive_bit_clock) |-> ##[0:1] rx_sample_en; endproperty
    a_rx_sample: assert property (p_rx_sample) else $error("no sample strobe");
    property p_tx_shift; $fell(transmit_bit_clock) |-> ##[0:1] tx_shift_en; endproperty
    a_tx_shift: assert property (p_tx_shift) else $error("no shift strobe");
    property p_rx_tick; $changed(receive_bit_clock) |-> rx_bit_tick; endproperty
    a_rx_tick: assert property (p_rx_tick) else $error("no edge strobe");
    property p_pin_oe; (receive_pin_drive_sel != 3'h0) [*3] |-> receive_clock_pin_oe; endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("pin not driven");
endmodule
bind scrg_rate_gen scrg_rate_gen_monitor u_mon (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .receive_pin_drive_sel, .receive_bit_clock,
    .transmit_bit_clock, .receive_clock_pin_oe, .rx_sample_en, .rx_bit_tick, .tx_shift_en,
    .zero_irq);
`default_nettype wire

//--- test/tb_scrg_rate_gen.sv
// random and corner tests of the serial clock rate generator
`timescale 1ns/1ns
`default_nettype none
module tb_scrg_rate_gen;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr, sel;
    logic [31:0] wdata, d;
    logic [5:0] pv;
    logic [1:0] r;
    wire awready, wready, bvalid, arready, rvalid, rbc, tbc, pref, rpo, rpoe, tpo, tpoe, zirq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer mismatches, checks, n, c, t, u;
    scrg_rate_gen dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .receive_clock_pin(pv[0]), .transmit_clock_pin(pv[1]), .port_pin_a(pv[2]),
        .port_pin_b(pv[3]), .pll_receive_clock(pv[4]), .pll_transmit_clock(pv[5]),
        .receive_pin_drive_sel(sel[2:0]), .transmit_pin_drive_sel(sel[5:3]),
        .pll_reference_sel(sel[7:6]), .receive_bit_clock(rbc), .transmit_bit_clock(tbc),
        .pll_reference(pref), .receive_clock_pin_out(rpo), .receive_clock_pin_oe(rpoe),
        .transmit_clock_pin_out(tpo), .transmit_clock_pin_oe(tpoe), .rx_sample_en(),
        .tx_shift_en(), .rx_bit_tick(), .tx_bit_tick(), .zero_irq(zirq));
    // a clock pin is never driven from its own pin code, so codes 1 and 2 drive low
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // ====
    // tasks
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("mismatch %0t %h %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        begin
            @(posedge aclk);
            {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
            do begin
                @(posedge aclk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (!bvalid);
            r = bresp;
            bready <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge aclk);
            {araddr, arvalid, rready} <= {a, 2'b11};
            do begin
                @(posedge aclk);
                if (arready) arvalid <= 1'b0;
            end while (!rvalid);
            {d, r} = {rdata, rresp};
            rready <= 1'b0;
        end
    endtask
    // k rising edges on all four clock pins, counting bit clock changes
    task pulses(input integer k);
        integer i;
        logic lr, lt;
        begin
            {t, u, lr, lt} = {64'h0, rbc, tbc};
            for (i = 0; i < 6 * k + 6; i = i + 1) begin
                @(posedge aclk);
                if (i < 6 * k) pv[3:0] <= (i % 6 < 3) ? 4'hF : 4'h0;
                if (rbc !== lr) t = t + 1;
                if (tbc !== lt) u = u + 1;
                {lr, lt} = {rbc, tbc};
            end
        end
    endtask
    task flag(input [31:0] e);
        begin
            rd(8'h10);
            chk(d & 32'h2, e);
        end
    endtask
    function logic src(input logic [2:0] code, input logic tx);
        case (code)
            3'h1: src = pv[0];
            3'h2: src = pv[1];
            3'h3: src = tx ? pv[5] : pv[4];
            3'h6: src = pv[2];
            3'h7: src = pv[3];
            default: src = 1'b0;
        endcase
    endfunction
    task results;
        begin
            if (mismatches == 0 && checks > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches = mismatches + 1;
        results;
    end
    // ====
    // main sequence
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, aresetn} = 6'h0;
        {awaddr, araddr, sel, wdata, pv} = 62'h0;
        mismatches = 0;
        checks = 0;
        n = $urandom(33);
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        n = $urandom & 32'hFFFF;
        wr(8'h08, n);
        rd(8'h08);
        chk(d, n);
        wr(8'h1C, 32'h1);
        chk(r, 2'h2);
        rd(8'h1C);
        chk({d[29:0], r}, 32'h2);
        wr(8'h14, 32'h20);
        for (c = 0; c < 8; c = c + 1) begin
            if (c == 4 || c == 5) continue;
            pv <= 6'($urandom);
            sel <= {2'h2, c[2:0], c[2:0]};
            wr(8'h00, {26'h0, c[2:0], c[2:0]});
            repeat (6) @(posedge aclk);
            chk({rbc, tbc, rpo, tpo, rpoe, tpoe, pref}, {src(c[2:0], 1'b0), src(c[2:0], 1'b1),
                (c > 2) & src(c[2:0], 1'b0), (c > 2) & src(c[2:0], 1'b1),
                {2{c != 0}}, pv[0]});
        end
        pv <= 6'h0;
        wr(8'h14, 32'h0);
        for (c = 0; c < 4; c = c + 1) begin
            wr(8'h04, c << 14);
            wr(8'h00, 32'h903E);
            pulses(32);
            chk(t, 2 << c);
            chk(u, 2 << c);
        end
        wr(8'h04, 32'h2C00);
        wr(8'h00, 32'h803E);
        pulses(32);
        chk(t, 0);
        chk(u, 16);
        n = 2 + $urandom % 4;
        wr(8'h00, 32'h0200);
        wr(8'h08, n);
        wr(8'h04, 32'h3);
        wr(8'h14, 32'h4000);
        pulses(n - 1);
        wr(8'h18, 32'h1);
        rd(8'h08);
        chk(d, 1);
        flag(0);
        pulses(2);
        flag(2);
        wr(8'h18, 32'h34);
        repeat (2) @(posedge aclk);
        chk(zirq, 1);
        wr(8'h18, 32'h14);
        repeat (2) @(posedge aclk);
        chk(zirq, 0);
        wr(8'h10, 32'h2);
        flag(0);
        pulses(n + 1);
        flag(0);
        wr(8'h14, 32'h4000);
        pulses(n + 1);
        flag(2);
        wr(8'h04, 32'h2);
        wr(8'h10, 32'h2);
        wr(8'h14, 32'h4000);
        pulses(n);
        flag(0);
        wr(8'h04, 32'h1);
        wr(8'h14, 32'h4000);
        pulses(n + 1);
        wr(8'h10, 32'h2);
        pulses(n + 1);
        flag(2);
        // divider a as receive bit clock: two output periods in 2(N+1) input periods
        wr(8'h00, 32'h0204);
        repeat (2) @(posedge aclk);
        pulses(2 * n + 2);
        chk(t, 4);
        results;
    end
endmodule
`default_nettype wire
